// ==== shared/tmr_pkg.sv ====
// Purpose: constants and types shared by the triple timer block
// Assumes: 8-bit register port, 10 MHz clock, all inputs synchronous
// Notes:   each timer owns a 16-byte register window, window 3 is global
package tmr_pkg;
  localparam int         NUM_TMR    = 3;
  localparam int         CLK_HZ     = 10000000;
  localparam int         ICK_DIV    = 4;           // instruction clock is clock/4
  localparam logic [1:0] ICK_LAST   = 2'(ICK_DIV - 1);
  // offsets inside a timer window
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_GCTRL  = 4'h1;
  localparam logic [3:0] OFS_CNTL   = 4'h2;
  localparam logic [3:0] OFS_CNTH   = 4'h3;
  localparam logic [3:0] OFS_CKPIN  = 4'h4;
  localparam logic [3:0] OFS_GPIN   = 4'h5;
  localparam logic [3:0] OFS_CMPL   = 4'h6;
  localparam logic [3:0] OFS_CMPH   = 4'h7;
  localparam logic [3:0] OFS_CCPM   = 4'h8;
  // global window and its offsets
  localparam logic [1:0] WIN_GLOBAL = 2'h3;
  localparam logic [3:0] OFS_STL    = 4'h0;
  localparam logic [3:0] OFS_STH    = 4'h1;
  localparam logic [3:0] OFS_MSKL   = 4'h2;
  localparam logic [3:0] OFS_MSKH   = 4'h3;
  localparam logic [3:0] OFS_IRQC   = 4'h4;
  // control, gate control and unit mode fields
  localparam int         CTRL_RUN   = 0;
  localparam int         CTRL_SYNC  = 2;
  localparam int         CTRL_SOSC  = 3;
  localparam int         CTRL_PS    = 4;
  localparam int         CTRL_CS    = 6;
  localparam logic [7:0] CTRL_WMASK = 8'hfd;
  localparam int         GC_EN      = 7;
  localparam int         GC_POL     = 6;
  localparam int         GC_TOG     = 5;
  localparam int         GC_SP      = 4;
  localparam int         GC_GO      = 3;
  localparam int         GC_SS      = 0;
  localparam logic [7:0] GC_WMASK   = 8'hfb;
  localparam logic [7:0] GC_VBIT    = 8'h04;
  localparam int         CCP_CAP    = 0;
  localparam int         CCP_CMP    = 1;
  localparam int         CCP_TRIG   = 2;
  // status and mask layout, global irq control
  localparam int          ST_OVF    = 0;
  localparam int          ST_GATE   = 4;
  localparam int          ST_CCP    = 8;
  localparam logic [15:0] ST_VALID  = 16'h0777;
  localparam int          IRQC_PERIPHERAL_IRQ_ENABLE = 0;
  localparam int          IRQC_GIE  = 1;

  typedef enum logic [1:0] {
    CS_ICK = 2'b00,
    CS_SYS = 2'b01,
    CS_PIN = 2'b10,
    CS_ALT = 2'b11
  } tmr_cs_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tmr_bus_type;

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  gctrl;
    logic [15:0] count;
    logic [4:0]  ckpin;
    logic [4:0]  gpin;
    logic [15:0] ccpr;
    logic [2:0]  ccpm;
    logic        match;
    logic        cmp_evt;
  } tmr_chan_type;

  typedef struct packed {
    tmr_chan_type [NUM_TMR-1:0] ch;
    logic [15:0]                status;
    logic [15:0]                mask;
    logic [1:0]                 irqc;
    logic [7:0]                 rdata;
    logic [1:0]                 idiv;
    logic                       trig;
  } tmr_state_type;

  localparam tmr_state_type STATE_RST = '0;
endpackage : tmr_pkg

// ==== logic/tmr_prescale.sv ====
// Purpose: clock source selection, sleep gating and prescaler of one timer
// Assumes: external and oscillator inputs are synchronous to the clock
// Notes:   o_inc is a one-cycle count pulse
`timescale 1ns/10ps
module tmr_prescale (
  input  wire logic                i_mclk,
  input  wire logic                i_rst,
  input  wire tmr_pkg::tmr_cs_type i_cs,
  input  wire logic                i_sosc_sel,
  input  wire logic                i_pin,
  input  wire logic                i_sosc,
  input  wire logic                i_ick_tick,
  input  wire logic                i_sleep,
  input  wire logic                i_sync,
  input  wire logic                i_run,
  input  wire logic                i_gate_ok,
  input  wire logic [1:0]          i_ps,
  output logic                     o_inc
);
  typedef struct packed {
    logic       ext;
    logic [2:0] div;
    logic       inc;
  } tmr_ps_type;

  tmr_ps_type s_q;
  tmr_ps_type s_d;
  logic       ext_now;
  logic       tick;
  logic [2:0] mask;

  // pick the source, qualify it for sleep, divide by 1/2/4/8
  always_comb
  begin
    s_d     = s_q;
    ext_now = (i_cs == tmr_pkg::CS_ALT || i_sosc_sel) ? i_sosc : i_pin;
    unique case (i_cs)
      tmr_pkg::CS_ICK: tick = i_ick_tick & ~i_sleep;
      tmr_pkg::CS_SYS: tick = ~i_sleep;
      tmr_pkg::CS_PIN,
      tmr_pkg::CS_ALT: tick = ext_now & ~s_q.ext & (~i_sleep | i_sync);
    endcase
    mask      = 3'h7 >> (2'h3 - i_ps);
    s_d.ext   = ext_now;
    s_d.inc   = 1'b0;
    if (!i_run)
      s_d.div = 3'h0;
    else if (tick && i_gate_ok)
    begin
      if ((s_q.div & mask) == mask)
      begin
        s_d.div = 3'h0;
        s_d.inc = 1'b1;
      end
      else
        s_d.div = s_q.div + 3'h1;
    end
  end

  // state register
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign o_inc = s_q.inc;

  a_sleep_hold:
  assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_sleep && !(i_sync && i_cs[1])) |=> !o_inc)
    else $error("timer advanced in sleep without async source");
endmodule : tmr_prescale

// ==== logic/tmr_gate.sv ====
// Purpose: gate source, polarity, toggle and single-pulse logic of one timer
// Assumes: gate inputs synchronous to the clock
// Notes:   value, falling edge and done are registered
`timescale 1ns/10ps
module tmr_gate (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_pin,
  input  wire logic       i_alt,
  input  wire logic [1:0] i_ss,
  input  wire logic       i_pol,
  input  wire logic       i_tog,
  input  wire logic       i_sp,
  input  wire logic       i_go,
  output logic            o_val,
  output logic            o_fall,
  output logic            o_done
);
  typedef struct packed {
    logic g;
    logic tog;
    logic base;
    logic act;
    logic val;
    logic fall;
    logic done;
  } tmr_gt_type;

  tmr_gt_type s_q;
  tmr_gt_type s_d;
  logic       g;

  // polarity, toggle flop, then single-pulse window
  always_comb
  begin
    s_d      = s_q;
    g        = ((i_ss == 2'h0) ? i_pin : i_alt) ^ ~i_pol;
    s_d.g    = g;
    s_d.fall = 1'b0;
    s_d.done = 1'b0;
    if (!i_tog)
      s_d.tog = 1'b0;
    else if (g && !s_q.g)
      s_d.tog = ~s_q.tog;
    s_d.base = i_tog ? s_d.tog : g;
    if (!i_sp)
      s_d.act = 1'b0;
    else if (!s_q.act && i_go && s_d.base && !s_q.base)
      s_d.act = 1'b1;
    else if (s_q.act && !s_d.base)
    begin
      s_d.act  = 1'b0;
      s_d.done = 1'b1; // single pulse finished
    end
    s_d.val  = i_sp ? s_d.act : s_d.base;
    s_d.fall = s_q.val & ~s_d.val;
  end

  // state register
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign o_val  = s_q.val;
  assign o_fall = s_q.fall;
  assign o_done = s_q.done;
endmodule : tmr_gate

// ==== logic/tmr_top.sv ====
// Purpose: three 16-bit timers with gate, capture/compare time base
// Assumes: byte register port, read data one cycle after the strobe
// Notes:   window n (addr[5:4]) is timer n, window 3 holds status,
//          mask and irq control; count writes beat trigger clears
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module tmr_top (
  input  wire logic        I_MCLK,
  input  wire logic        I_RST,
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [7:0]  I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [7:0]  O_RDATA,
  input  wire logic [31:0] I_PINS,
  input  wire logic        I_SOSC,
  input  wire logic [2:0]  I_GATE_ALT,
  input  wire logic [2:0]  I_CAP_EVT,
  input  wire logic        I_SLEEP,
  output logic      [2:0]  O_CMP_EVT,
  output logic             O_ADC_TRIG,
  output logic             O_IRQ,
  output logic             O_WAKE,
  output logic             O_VECTOR,
  output logic             O_SOSC_EN
);
  localparam int N = tmr_pkg::NUM_TMR;

  tmr_pkg::tmr_bus_type   bus;
  tmr_pkg::tmr_state_type s_q;
  tmr_pkg::tmr_state_type s_d;
  logic [N-1:0]           inc;
  logic [N-1:0]           gval;
  logic [N-1:0]           gfall;
  logic [N-1:0]           gdone;
  logic [N-1:0]           win_sel;
  logic [N-1:0]           hit;
  logic [N-1:0]           cwr;
  logic [N-1:0]           sosc_use;
  logic                   ick_tick;
  logic                   glb_sel;
  logic                   pend;

  // register port bundled into one carrier
  assign bus      = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};
  assign glb_sel  = (bus.addr[5:4] == tmr_pkg::WIN_GLOBAL);
  assign ick_tick = (s_q.idiv == tmr_pkg::ICK_LAST);

  // one timer channel per generate pass
  generate
    for (genvar gi = 0; gi < N; gi++)
    begin : g_tmr
      assign win_sel[gi]  = (bus.addr[5:4] == 2'(gi));
      assign cwr[gi]      = bus.wr && win_sel[gi] &&
                            (bus.addr[3:0] == tmr_pkg::OFS_CNTL ||
                             bus.addr[3:0] == tmr_pkg::OFS_CNTH);
      assign hit[gi]      = s_q.ch[gi].ccpm[tmr_pkg::CCP_CMP] &
                            ~s_q.ch[gi].ccpm[tmr_pkg::CCP_CAP] &
                            (s_q.ch[gi].ccpr == s_q.ch[gi].count);
      assign sosc_use[gi] = s_q.ch[gi].ctrl[tmr_pkg::CTRL_SOSC] |
                            (s_q.ch[gi].ctrl[tmr_pkg::CTRL_CS +: 2] ==
                             tmr_pkg::CS_ALT);

      tmr_prescale u_ps (
        .i_mclk     (I_MCLK),
        .i_rst      (I_RST),
        .i_cs       (tmr_pkg::tmr_cs_type'(s_q.ch[gi].ctrl[tmr_pkg::CTRL_CS +: 2])),
        .i_sosc_sel (s_q.ch[gi].ctrl[tmr_pkg::CTRL_SOSC]),
        .i_pin      (I_PINS[s_q.ch[gi].ckpin]),
        .i_sosc     (I_SOSC),
        .i_ick_tick (ick_tick),
        .i_sleep    (I_SLEEP),
        .i_sync     (s_q.ch[gi].ctrl[tmr_pkg::CTRL_SYNC]),
        .i_run      (s_q.ch[gi].ctrl[tmr_pkg::CTRL_RUN]),
        .i_gate_ok  (~s_q.ch[gi].gctrl[tmr_pkg::GC_EN] | gval[gi]),
        .i_ps       (s_q.ch[gi].ctrl[tmr_pkg::CTRL_PS +: 2]),
        .o_inc      (inc[gi])
      );

      tmr_gate u_gt (
        .i_mclk (I_MCLK),
        .i_rst  (I_RST),
        .i_pin  (I_PINS[s_q.ch[gi].gpin]),
        .i_alt  (I_GATE_ALT[gi]),
        .i_ss   (s_q.ch[gi].gctrl[tmr_pkg::GC_SS +: 2]),
        .i_pol  (s_q.ch[gi].gctrl[tmr_pkg::GC_POL]),
        .i_tog  (s_q.ch[gi].gctrl[tmr_pkg::GC_TOG]),
        .i_sp   (s_q.ch[gi].gctrl[tmr_pkg::GC_SP]),
        .i_go   (s_q.ch[gi].gctrl[tmr_pkg::GC_GO]),
        .o_val  (gval[gi]),
        .o_fall (gfall[gi]),
        .o_done (gdone[gi])
      );

      assign O_CMP_EVT[gi] = s_q.ch[gi].cmp_evt;

      // capture request that is not overridden by a value write
      sequence s_cap_take;
        I_CAP_EVT[gi] && s_q.ch[gi].ccpm[tmr_pkg::CCP_CAP] &&
        !(bus.wr && win_sel[gi] && bus.addr[3:1] == 3'h3);
      endsequence

      // first cycle of a match with trigger armed and no count write
      sequence s_trig_hit;
        hit[gi] && !s_q.ch[gi].match &&
        s_q.ch[gi].ccpm[tmr_pkg::CCP_TRIG] && !cwr[gi];
      endsequence

      a_count_write:
      assert property (@(posedge I_MCLK) disable iff (I_RST)
        (bus.wr && win_sel[gi] && bus.addr[3:0] == tmr_pkg::OFS_CNTL)
        |=> (s_q.ch[gi].count[7:0] == $past(I_WDATA)))
        else $error("count low write did not take effect");

      a_trig_clear:
      assert property (@(posedge I_MCLK) disable iff (I_RST)
        s_trig_hit |=> (s_q.ch[gi].count == 16'h0000) && O_ADC_TRIG)
        else $error("trigger did not clear the count");

      a_ovf_cause:
      assert property (@(posedge I_MCLK) disable iff (I_RST)
        $rose(s_q.status[tmr_pkg::ST_OVF + gi])
        |-> $past(inc[gi] && s_q.ch[gi].count == 16'hffff))
        else $error("overflow flag set without a wrap");

      a_capture_copy:
      assert property (@(posedge I_MCLK) disable iff (I_RST)
        s_cap_take |=> (s_q.ch[gi].ccpr == $past(s_q.ch[gi].count)))
        else $error("capture did not copy the count");

      a_match_event:
      assert property (@(posedge I_MCLK) disable iff (I_RST)
        O_CMP_EVT[gi] |-> $past(hit[gi]) && !$past(s_q.ch[gi].match))
        else $error("compare event without a fresh match");

      a_gate_flag:
      assert property (@(posedge I_MCLK) disable iff (I_RST)
        gfall[gi] |=> s_q.status[tmr_pkg::ST_GATE + gi])
        else $error("gate fall did not set its flag");

      a_trig_no_ovf:
      assert property (@(posedge I_MCLK) disable iff (I_RST)
        (hit[gi] && !s_q.ch[gi].match && s_q.ch[gi].ccpm[tmr_pkg::CCP_TRIG] &&
         !s_q.status[tmr_pkg::ST_OVF + gi] && !(inc[gi] && &s_q.ch[gi].count))
        |=> !s_q.status[tmr_pkg::ST_OVF + gi])
        else $error("trigger clear set the overflow flag");

      a_trig_event:
      assert property (@(posedge I_MCLK) disable iff (I_RST)
        s_trig_hit |=> O_CMP_EVT[gi] && s_q.status[tmr_pkg::ST_CCP + gi])
        else $error("trigger match without compare event");

      a_count_high:
      assert property (@(posedge I_MCLK) disable iff (I_RST)
        (bus.wr && win_sel[gi] && bus.addr[3:0] == tmr_pkg::OFS_CNTH)
        |=> (s_q.ch[gi].count[15:8] == $past(I_WDATA)))
        else $error("count high write did not take effect");

      a_wrap_flag:
      assert property (@(posedge I_MCLK) disable iff (I_RST)
        (inc[gi] && s_q.ch[gi].count == 16'hffff && !cwr[gi] && !hit[gi])
        |=> (s_q.ch[gi].count == 16'h0000) && s_q.status[tmr_pkg::ST_OVF + gi])
        else $error("count did not wrap with overflow flag");

      a_cap_flag:
      assert property (@(posedge I_MCLK) disable iff (I_RST)
        s_cap_take |=> s_q.status[tmr_pkg::ST_CCP + gi])
        else $error("capture did not set the unit flag");

      // with compare and trigger armed, a count at or below the compare value never passes it
      a_period_bound:
      assert property (@(posedge I_MCLK) disable iff (I_RST)
        (s_q.ch[gi].ccpm[tmr_pkg::CCP_TRIG] && s_q.ch[gi].ccpm[tmr_pkg::CCP_CMP] &&
         !s_q.ch[gi].ccpm[tmr_pkg::CCP_CAP] && !s_q.ch[gi].match && !cwr[gi] &&
         s_q.ch[gi].count <= s_q.ch[gi].ccpr &&
         !(bus.wr && win_sel[gi] && bus.addr[3:1] == 3'h3))
        |=> (s_q.ch[gi].count <= s_q.ch[gi].ccpr))
        else $error("count ran past the compare period");

      a_sosc_sel:
      assert property (@(posedge I_MCLK) disable iff (I_RST)
        sosc_use[gi] |-> O_SOSC_EN)
        else $error("secondary oscillator off while a timer uses it");
    end
  endgenerate

  // next state: global registers, then per-timer events and registers
  always_comb
  begin
    s_d       = s_q;
    s_d.idiv  = s_q.idiv + 2'h1;
    s_d.trig  = 1'b0;
    s_d.rdata = 8'h00;
    // global window; status clears first so events below win
    if (bus.wr && glb_sel)
    begin
      case (bus.addr[3:0])
        tmr_pkg::OFS_STL:  s_d.status[7:0]  = s_q.status[7:0] & ~bus.wdata;
        tmr_pkg::OFS_STH:  s_d.status[15:8] = s_q.status[15:8] & ~bus.wdata;
        tmr_pkg::OFS_MSKL: s_d.mask[7:0]    = bus.wdata & tmr_pkg::ST_VALID[7:0];
        tmr_pkg::OFS_MSKH: s_d.mask[15:8]   = bus.wdata & tmr_pkg::ST_VALID[15:8];
        tmr_pkg::OFS_IRQC: s_d.irqc         = bus.wdata[1:0];
        default: ;
      endcase
    end
    if (bus.rd && glb_sel)
    begin
      case (bus.addr[3:0])
        tmr_pkg::OFS_STL:  s_d.rdata = s_q.status[7:0];
        tmr_pkg::OFS_STH:  s_d.rdata = s_q.status[15:8];
        tmr_pkg::OFS_MSKL: s_d.rdata = s_q.mask[7:0];
        tmr_pkg::OFS_MSKH: s_d.rdata = s_q.mask[15:8];
        tmr_pkg::OFS_IRQC: s_d.rdata = {6'h00, s_q.irqc};
        default:           s_d.rdata = 8'h00;
      endcase
    end
    for (int i = 0; i < N; i++)
    begin
      s_d.ch[i].cmp_evt = 1'b0;
      // count advance; wrap to zero flags overflow
      if (inc[i])
      begin
        s_d.ch[i].count = s_q.ch[i].count + 16'h0001;
        if (s_q.ch[i].count == 16'hffff)
          s_d.status[tmr_pkg::ST_OVF + i] = 1'b1;
      end
      // compare edge: event, unit flag, optional trigger clear
      s_d.ch[i].match = hit[i];
      if (hit[i] && !s_q.ch[i].match)
      begin
        s_d.ch[i].cmp_evt = 1'b1;
        s_d.status[tmr_pkg::ST_CCP + i] = 1'b1;
        if (s_q.ch[i].ccpm[tmr_pkg::CCP_TRIG])
        begin
          s_d.ch[i].count = 16'h0000;
          s_d.trig        = 1'b1;
        end
      end
      // capture copies the whole count
      if (I_CAP_EVT[i] && s_q.ch[i].ccpm[tmr_pkg::CCP_CAP])
      begin
        s_d.ch[i].ccpr = s_q.ch[i].count;
        s_d.status[tmr_pkg::ST_CCP + i] = 1'b1;
      end
      if (gfall[i])
        s_d.status[tmr_pkg::ST_GATE + i] = 1'b1;
      if (gdone[i])
        s_d.ch[i].gctrl[tmr_pkg::GC_GO] = 1'b0;
      // timer window writes, applied last so they take precedence
      if (bus.wr && win_sel[i])
      begin
        case (bus.addr[3:0])
          tmr_pkg::OFS_CTRL:  s_d.ch[i].ctrl  = bus.wdata & tmr_pkg::CTRL_WMASK;
          tmr_pkg::OFS_GCTRL: s_d.ch[i].gctrl = bus.wdata & tmr_pkg::GC_WMASK;
          tmr_pkg::OFS_CNTL:  s_d.ch[i].count = {s_q.ch[i].count[15:8], bus.wdata};
          tmr_pkg::OFS_CNTH:  s_d.ch[i].count = {bus.wdata, s_q.ch[i].count[7:0]};
          tmr_pkg::OFS_CKPIN: s_d.ch[i].ckpin = bus.wdata[4:0];
          tmr_pkg::OFS_GPIN:  s_d.ch[i].gpin  = bus.wdata[4:0];
          tmr_pkg::OFS_CMPL:  s_d.ch[i].ccpr[7:0]  = bus.wdata;
          tmr_pkg::OFS_CMPH:  s_d.ch[i].ccpr[15:8] = bus.wdata;
          tmr_pkg::OFS_CCPM:  s_d.ch[i].ccpm = bus.wdata[2:0];
          default: ;
        endcase
      end
      // timer window reads, unimplemented bits as zero
      if (bus.rd && win_sel[i])
      begin
        case (bus.addr[3:0])
          tmr_pkg::OFS_CTRL:  s_d.rdata = s_q.ch[i].ctrl;
          tmr_pkg::OFS_GCTRL: s_d.rdata = s_q.ch[i].gctrl |
                                          (gval[i] ? tmr_pkg::GC_VBIT : 8'h00);
          tmr_pkg::OFS_CNTL:  s_d.rdata = s_q.ch[i].count[7:0];
          tmr_pkg::OFS_CNTH:  s_d.rdata = s_q.ch[i].count[15:8];
          tmr_pkg::OFS_CKPIN: s_d.rdata = {3'h0, s_q.ch[i].ckpin};
          tmr_pkg::OFS_GPIN:  s_d.rdata = {3'h0, s_q.ch[i].gpin};
          tmr_pkg::OFS_CMPL:  s_d.rdata = s_q.ch[i].ccpr[7:0];
          tmr_pkg::OFS_CMPH:  s_d.rdata = s_q.ch[i].ccpr[15:8];
          tmr_pkg::OFS_CCPM:  s_d.rdata = {5'h00, s_q.ch[i].ccpm};
          default:            s_d.rdata = 8'h00;
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
      s_q <= tmr_pkg::STATE_RST;
    else
      s_q <= s_d;
  end

  // interrupt, wake and vector request
  assign pend       = |(s_q.status & s_q.mask);
  assign O_IRQ      = pend & s_q.irqc[tmr_pkg::IRQC_PERIPHERAL_IRQ_ENABLE];
  assign O_WAKE     = O_IRQ & I_SLEEP;
  assign O_VECTOR   = O_IRQ & s_q.irqc[tmr_pkg::IRQC_GIE];
  assign O_SOSC_EN  = |sosc_use;
  assign O_ADC_TRIG = s_q.trig;
  assign O_RDATA    = s_q.rdata;

  a_unimpl_zero:
  assert property (@(posedge I_MCLK) disable iff (I_RST)
    (bus.rd && !glb_sel && bus.addr[3:1] == 3'h2) |=> (O_RDATA[7:5] == 3'h0))
    else $error("unimplemented pin select bits read nonzero");

  a_ctrl_bit_zero:
  assert property (@(posedge I_MCLK) disable iff (I_RST)
    (bus.rd && !glb_sel && bus.addr[3:0] == tmr_pkg::OFS_CTRL) |=> !O_RDATA[1])
    else $error("unimplemented control bit read nonzero");

  a_wake_cond:
  assert property (@(posedge I_MCLK) disable iff (I_RST)
    (I_SLEEP && s_q.irqc[tmr_pkg::IRQC_PERIPHERAL_IRQ_ENABLE] && pend) iff O_WAKE)
    else $error("wake output disagrees with enables");

  a_vector_gie:
  assert property (@(posedge I_MCLK) disable iff (I_RST)
    O_VECTOR |-> O_IRQ && s_q.irqc[tmr_pkg::IRQC_GIE])
    else $error("vector request without global enable");

  a_sosc_run:
  assert property (@(posedge I_MCLK) disable iff (I_RST)
    s_q.ch[0].ctrl[tmr_pkg::CTRL_SOSC] |-> O_SOSC_EN)
    else $error("secondary oscillator stopped while selected");
endmodule : tmr_top

// ==== tb/tmr_unit_model.sv ====
// Purpose: far-side model: capture unit event source and external count clock
// Assumes: every output changes just after a rising clock edge
// Notes:   capture events are one cycle long, the pin clock idles low
`timescale 1ns/10ps
module tmr_unit_model (
  input  wire logic        i_mclk,
  input  wire logic [2:0]  i_cap_req,
  input  wire logic        i_clk_en,
  output logic      [2:0]  o_cap_evt = 3'h0,
  output logic      [31:0] o_pins = 32'h0,
  output logic             o_sosc = 1'b0
);
  logic [2:0] req_q = 3'h0;
  logic [1:0] div_q = 2'h0;
  // one capture event for each rising request
  always_ff @(posedge i_mclk)
  begin
    req_q     <= i_cap_req;
    o_cap_evt <= i_cap_req & ~req_q;
  end
  // pin 7 clock at a quarter rate, stands still while disabled
  always_ff @(posedge i_mclk)
  begin
    div_q  <= i_clk_en ? div_q + 2'h1 : 2'h0;
    o_pins <= {24'h0, div_q[1], 7'h0};
    o_sosc <= div_q[1];
  end
endmodule : tmr_unit_model

// ==== tb/testbench.sv ====
// Purpose: self-checking bench of the triple timer block
// Assumes: byte register port, read data in the cycle after the strobe
// Notes:   reads note their expectation in a queue, a watcher compares
`timescale 1ns/10ps
module testbench;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h0;
  logic [7:0]  wdata = 8'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        sleep = 1'b0;
  logic [2:0]  gate_alt = 3'h0;
  logic [2:0]  cap_req = 3'h0;
  logic        clk_en = 1'b0;
  logic [7:0]  rdata;
  logic [31:0] pins;
  logic        sosc;
  logic [2:0]  cap_evt;
  logic [2:0]  cmp_evt;
  logic        adc_trig;
  logic        irq;
  logic        wake;
  logic        vector;
  logic        sosc_en;
  logic        rd_q = 1'b0;
  logic [15:0] expq[$];
  logic [15:0] note;
  logic [15:0] val;
  logic [7:0]  got;
  logic [7:0]  base;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          last_trig = 0;
  int          trig_n = 0;
  int          e;

  always #50 mclk = ~mclk;

  tmr_top tmr_top_inst (.I_MCLK(mclk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_PINS(pins), .I_SOSC(sosc),
    .I_GATE_ALT(gate_alt), .I_CAP_EVT(cap_evt), .I_SLEEP(sleep), .O_CMP_EVT(cmp_evt),
    .O_ADC_TRIG(adc_trig), .O_IRQ(irq), .O_WAKE(wake), .O_VECTOR(vector),
    .O_SOSC_EN(sosc_en));
  tmr_unit_model tmr_unit_model_inst (.i_mclk(mclk), .i_cap_req(cap_req),
    .i_clk_en(clk_en), .o_cap_evt(cap_evt), .o_pins(pins), .o_sosc(sosc));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  // one-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  // one-cycle read strobe; m selects the bits that are compared
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] d);
    @(posedge mclk);
    rd   <= 1'b1;
    addr <= a;
    expq.push_back({m, d});
    @(posedge mclk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask : rd_reg

  // watcher: read data and spacing of conversion triggers
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    rd_q <= rd;
    if (rd_q)
    begin
      note = expq.pop_front();
      check("read data", 16'(rdata & note[15:8]), 16'(note[7:0] & note[15:8]));
    end
    if (adc_trig === 1'b1)
    begin
      if (trig_n > 0)
        check("trigger period", 16'(cyc - last_trig), 16'(tmr_pkg::ICK_DIV * 5));
      check("compare event", 16'(cmp_evt), 16'h0004);
      last_trig <= cyc;
      trig_n <= trig_n + 1;
    end
  end

  // watchdog cuts a hang short
  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    results();
  end

  initial
  begin
    void'($urandom(32'hf84dd0d5));
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    // reset value, count bytes and loose bits of every timer
    for (int n = 0; n < 3; n++)
    begin
      base = 8'(n * 16);
      rd_reg(base, 8'hff, 8'h00);
      val = 16'($urandom());
      wr_reg(base | 8'h02, val[7:0]);
      wr_reg(base | 8'h03, val[15:8]);
      rd_reg(base | 8'h02, 8'hff, val[7:0]);
      rd_reg(base | 8'h03, 8'hff, val[15:8]);
      wr_reg(base, 8'hfe);
      rd_reg(base, 8'hff, 8'hfc);
      wr_reg(base, 8'h00);
      wr_reg(base | 8'h04, 8'hff);
      rd_reg(base | 8'h04, 8'hff, 8'h1f);
      rd_reg(base | 8'h0f, 8'hff, 8'h00);
    end
    // overflow of timer 0 and the interrupt chain
    wr_reg(8'h02, 8'hfd);
    wr_reg(8'h03, 8'hff);
    wr_reg(8'h32, 8'h01);
    wr_reg(8'h34, 8'h01);
    wr_reg(8'h00, 8'h41);
    for (int i = 0; i < 20 && irq !== 1'b1; i++)
      @(posedge mclk);
    wr_reg(8'h00, 8'h00);
    #1;
    check("irq", irq, 1'b1);
    check("vector", vector, 1'b0);
    rd_reg(8'h30, 8'hff, 8'h01);
    sleep <= 1'b1;
    wr_reg(8'h34, 8'h03);
    #1;
    check("wake", wake, 1'b1);
    check("vector", vector, 1'b1);
    wr_reg(8'h32, 8'h00);
    #1;
    check("masked irq", irq, 1'b0);
    wr_reg(8'h30, 8'h01);
    rd_reg(8'h30, 8'h01, 8'h00);
    // sleep: system clock stops, synced external pin counts
    wr_reg(8'h12, 8'h00);
    wr_reg(8'h14, 8'h07);
    wr_reg(8'h10, 8'h41);
    repeat (10) @(posedge mclk);
    rd_reg(8'h12, 8'hff, 8'h00);
    wr_reg(8'h10, 8'h85);
    clk_en <= 1'b1;
    repeat (40) @(posedge mclk);
    clk_en <= 1'b0;
    wr_reg(8'h10, 8'h00);
    rd_reg(8'h12, 8'h00, 8'h00);
    check("sleep pin count", 16'(got >= 8'h08 && got <= 8'h0b), 16'h1);
    wr_reg(8'h20, 8'h08);
    #1;
    check("osc enable", sosc_en, 1'b1);
    wr_reg(8'h20, 8'h00);
    sleep <= 1'b0;
    // prescaler codes on the system clock
    for (int k = 0; k < 4; k++)
    begin
      e = 64 >> k;
      wr_reg(8'h12, 8'h00);
      wr_reg(8'h10, 8'(8'h41 | (k << 4)));
      repeat (62) @(posedge mclk);
      wr_reg(8'h10, 8'h00);
      rd_reg(8'h12, 8'h00, 8'h00);
      check("prescaled count", 16'(int'(got) >= e - 2 && int'(got) <= e + 1), 16'h1);
    end
    // capture of a random count by timer 1
    val = 16'($urandom());
    wr_reg(8'h12, val[7:0]);
    wr_reg(8'h13, val[15:8]);
    wr_reg(8'h18, 8'h01);
    cap_req <= 3'h2;
    repeat (3) @(posedge mclk);
    cap_req <= 3'h0;
    rd_reg(8'h16, 8'hff, val[7:0]);
    rd_reg(8'h17, 8'hff, val[15:8]);
    rd_reg(8'h31, 8'h02, 8'h02);
    // compare with conversion trigger on timer 2
    wr_reg(8'h22, 8'h00);
    wr_reg(8'h23, 8'h00);
    wr_reg(8'h26, 8'h05);
    wr_reg(8'h27, 8'h00);
    wr_reg(8'h28, 8'h06);
    wr_reg(8'h30, 8'hff);
    wr_reg(8'h31, 8'hff);
    wr_reg(8'h20, 8'h01);
    repeat (80) @(posedge mclk);
    wr_reg(8'h20, 8'h00);
    check("trigger count", 16'(trig_n >= 3), 16'h1);
    rd_reg(8'h22, 8'h00, 8'h00);
    check("count below period", 16'(got <= 8'h05), 16'h1);
    rd_reg(8'h30, 8'h04, 8'h00);
    rd_reg(8'h31, 8'h04, 8'h04);
    // gate value fall with gate counting disabled
    wr_reg(8'h01, 8'h41);
    repeat (3) @(posedge mclk);
    wr_reg(8'h30, 8'hff);
    rd_reg(8'h30, 8'h10, 8'h00);
    gate_alt <= 3'h1;
    repeat (3) @(posedge mclk);
    gate_alt <= 3'h0;
    repeat (5) @(posedge mclk);
    rd_reg(8'h30, 8'h10, 8'h10);
    results();
  end
endmodule : testbench
